// ---- hdl/eew_array.sv ----
// 64-byte data array with self-timed erase-then-write cycle
`timescale 1ns/100ps
`default_nettype none
module eew_array
    import eew_pkg::*;
#(
    parameter int DEPTH = ARRAY_DEPTH,
    parameter int CYCLES = WRITE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Access
    input wire logic [ARRAY_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic start,
    input wire logic abort,
    output logic [7:0] rdata,
    // Status
    output logic busy,
    output logic done,
    output logic aborted
);
    logic [7:0] mem [DEPTH];
    logic [ARRAY_ADDR_W-1:0] addr_r;
    logic [7:0] data_r;
    logic [31:0] count_r;
    logic busy_r;
    logic finish;

    // First busy cycle of the timed write erases the byte, last busy cycle programs it
    assign finish = busy_r && (count_r == 32'd1);

    always_ff @(posedge clock) begin
        if (reset || abort) begin
            busy_r <= 1'b0;
            count_r <= 32'd0;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
            count_r <= 32'(CYCLES); // R17
        end else if (busy_r) begin
            count_r <= count_r - 32'd1;
            if (finish) begin
                busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (start && !busy_r) begin
            addr_r <= addr;
            data_r <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (busy_r && !abort && count_r == 32'(CYCLES)) begin
            mem[addr_r] <= ERASED_BYTE; // R16
        end else if (finish && !abort) begin
            mem[addr_r] <= data_r; // R16
        end
    end

    assign rdata = mem[addr];
    assign busy = busy_r;
    assign done = finish && !abort && !reset;
    assign aborted = busy_r && abort;
endmodule : eew_array
`default_nettype wire

// ---- hdl/eew_ctrl.sv ----
// Data EEPROM write control: registers, unlock gate, write and read sequencing
//
// Behaviour
// R01: Software loads location and byte before writing
// R02: Write starts only after 55h, AAh, start
// R03: Start bit ignored while write enable clear
// R04: Clearing write enable never stops active write
// R05: Hardware never clears the write enable bit
// R06: Write end clears start, sets complete flag
// R07: Only software clears the complete flag
// R08: Software masks interrupts around unlock sequence
// R09: Software keeps write enable clear when idle
// R10: Software reads back written byte to verify
// R11: Unlock port stores nothing, reads zero
// R12: Control reads zero after reset, error per cause
// R13: Buffer and location kept across warm reset
// R14: Write cut short by warm reset flags error
// R15: Read strobe loads buffer next cycle, self-clears
// R16: 64-byte array, erase then write per byte
// R17: Write duration set by on-chip timer
// R18: Any unexpected write resets the unlock detector
`timescale 1ns/100ps
`default_nettype none
module eew_ctrl
    import eew_pkg::*;
#(
    parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES
)
(
    // Clock and resets
    input wire logic clock,
    input wire logic reset,
    input wire logic warm_reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt and status
    output logic irq,
    output logic write_busy
);
    // Decoded accesses
    logic wr_buffer;
    logic wr_location;
    logic wr_control;
    logic wr_unlock;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic wr_other;

    // Register state
    logic [7:0] byte_buffer_r;
    logic [7:0] location_r;
    logic read_strobe_r;
    logic write_start_r;
    logic write_enable_r;
    logic write_error_r;
    logic write_complete_r;
    logic [IRQ_WIDTH-1:0] irq_status_r;
    logic [IRQ_WIDTH-1:0] irq_enable_r;
    logic [7:0] reg_rdata_r;

    // Verify tracking
    logic [7:0] last_data_r;
    logic [7:0] last_loc_r;
    logic last_valid_r;

    // Array and unlock links
    logic armed;
    logic start_ok;
    logic array_busy;
    logic array_done;
    logic array_aborted;
    logic [7:0] array_rdata;
    logic mismatch;
    logic [IRQ_WIDTH-1:0] irq_events;
    logic [7:0] control_view;

    // Writes during a warm reset are dropped; reads still answer
    always_comb begin
        wr_buffer = 1'b0;
        wr_location = 1'b0;
        wr_control = 1'b0;
        wr_unlock = 1'b0;
        wr_irq_clear = 1'b0;
        wr_irq_enable = 1'b0;
        wr_other = 1'b0;
        if (reg_wr && !warm_reset) begin
            if (reg_addr == OFS_BYTE_BUFFER) begin
                wr_buffer = 1'b1;
            end else if (reg_addr == OFS_LOCATION_SELECT) begin
                wr_location = 1'b1;
            end else if (reg_addr == OFS_CONTROL_STATUS) begin
                wr_control = 1'b1;
            end else if (reg_addr == OFS_UNLOCK_PORT) begin
                wr_unlock = 1'b1;
            end else if (reg_addr == OFS_IRQ_CLEAR) begin
                wr_irq_clear = 1'b1;
            end else if (reg_addr == OFS_IRQ_ENABLE) begin
                wr_irq_enable = 1'b1;
            end
            // Any write but one to the unlock port breaks the key sequence
            wr_other = !wr_unlock;
        end
    end

    // Unlock port has no storage; its writes only feed the detector
    eew_unlock u_unlock (
        .clock(clock),
        .reset(reset || warm_reset),
        .unlock_wr(wr_unlock), // R11
        .other_wr(wr_other), // R18
        .wdata(reg_wdata),
        .armed(armed)
    );

    // Enable is judged on its value before this write, so one write cannot
    // both enable and start
    assign start_ok = wr_control && reg_wdata[BIT_WRITE_START] && armed // R02
        && write_enable_r && !write_start_r; // R03

    // Warm reset aborts a running write; the cut byte may be left erased
    eew_array #(
        .DEPTH(ARRAY_DEPTH),
        .CYCLES(WRITE_CYCLE_COUNT)
    ) u_array (
        .clock(clock),
        .reset(reset),
        .addr(location_r[ARRAY_ADDR_W-1:0]),
        .wdata(byte_buffer_r), // R01
        .start(start_ok),
        .abort(warm_reset),
        .rdata(array_rdata),
        .busy(array_busy),
        .done(array_done),
        .aborted(array_aborted)
    );

    // Location register
    // All eight bits are kept; only the low six address the array
    always_ff @(posedge clock) begin
        if (reset) begin
            location_r <= RST_BYTE;
        end else if (wr_location) begin
            location_r <= reg_wdata; // R13
        end
    end

    // Byte buffer: software writes and completed reads both load it
    // A completing read beats a software write in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            byte_buffer_r <= RST_BYTE;
        end else if (read_strobe_r && !warm_reset) begin
            byte_buffer_r <= array_rdata; // R15
        end else if (wr_buffer) begin
            byte_buffer_r <= reg_wdata; // R13
        end
    end

    // Read strobe: settable only, lasts one cycle
    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            read_strobe_r <= 1'b0;
        end else if (read_strobe_r) begin
            read_strobe_r <= 1'b0; // R15
        end else if (wr_control && reg_wdata[BIT_READ_STROBE]) begin
            read_strobe_r <= 1'b1; // R15
        end
    end

    // Write start: set only by the unlocked sequence, cleared at completion
    // A start while busy is dropped, never queued
    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            write_start_r <= 1'b0;
        end else if (start_ok) begin
            write_start_r <= 1'b1; // R02
        end else if (array_done) begin
            write_start_r <= 1'b0; // R06
        end
    end

    // Write enable only follows software; the array ignores it once started
    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            write_enable_r <= 1'b0;
        end else if (wr_control) begin
            write_enable_r <= reg_wdata[BIT_WRITE_ENABLE]; // R05 R04
        end
    end

    // Write complete: hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            write_complete_r <= 1'b0; // R12
        end else if (array_done) begin
            write_complete_r <= 1'b1; // R06
        end else if (wr_control) begin
            write_complete_r <= reg_wdata[BIT_WRITE_COMPLETE]; // R07
        end
    end

    // Error flag: a write cut short by a warm reset leaves it set
    // Power-on clears it instead of leaving it unknown
    always_ff @(posedge clock) begin
        if (reset) begin
            write_error_r <= 1'b0; // R12
        end else if (array_aborted) begin
            write_error_r <= 1'b1; // R14
        end else if (warm_reset) begin
            write_error_r <= write_error_r; // R12
        end else if (array_done) begin
            write_error_r <= 1'b0;
        end else if (wr_control) begin
            write_error_r <= reg_wdata[BIT_WRITE_ERROR];
        end
    end

    // Remember the last byte written so a read-back can be checked in hardware
    // Limitation: only the most recent write can be checked
    always_ff @(posedge clock) begin
        if (reset) begin
            last_valid_r <= 1'b0;
            last_data_r <= RST_BYTE;
            last_loc_r <= RST_BYTE;
        end else if (start_ok) begin
            last_valid_r <= 1'b1;
            last_data_r <= byte_buffer_r;
            last_loc_r <= location_r;
        end else if (array_aborted) begin
            last_valid_r <= 1'b0;
        end
    end

    // A read of the last written location that differs means a weak cell
    assign mismatch = read_strobe_r && !warm_reset && last_valid_r && !array_busy
        && last_loc_r == location_r && array_rdata != last_data_r; // R10

    assign irq_events = {mismatch, array_aborted, array_done};

    // Sticky interrupt status; an event in the clear cycle is kept
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_WIDTH; gi++) begin : g_irq
            always_ff @(posedge clock) begin
                if (reset) begin
                    irq_status_r[gi] <= 1'b0;
                end else if (irq_events[gi]) begin
                    irq_status_r[gi] <= 1'b1;
                end else if (wr_irq_clear && reg_wdata[gi]) begin
                    irq_status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt enables survive a warm reset
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_enable_r <= RST_IRQ;
        end else if (wr_irq_enable) begin
            irq_enable_r <= reg_wdata[IRQ_WIDTH-1:0];
        end
    end

    // Bits 7 to 5 are not implemented and read as zero
    assign control_view = {3'h0, write_complete_r, write_error_r, write_enable_r,
        write_start_r, read_strobe_r};

    // Read data appear in the cycle after the strobe and only there
    // Unmapped and write-only offsets answer zero
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata_r <= RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == OFS_BYTE_BUFFER) begin
                reg_rdata_r <= byte_buffer_r;
            end else if (reg_addr == OFS_LOCATION_SELECT) begin
                reg_rdata_r <= location_r;
            end else if (reg_addr == OFS_CONTROL_STATUS) begin
                reg_rdata_r <= control_view;
            end else if (reg_addr == OFS_IRQ_STATUS) begin
                reg_rdata_r <= {5'h00, irq_status_r};
            end else if (reg_addr == OFS_IRQ_ENABLE) begin
                reg_rdata_r <= {5'h00, irq_enable_r};
            end else begin
                reg_rdata_r <= RST_BYTE; // R11
            end
        end else begin
            reg_rdata_r <= RST_BYTE;
        end
    end

    assign reg_rdata = reg_rdata_r;
    // Built only from registered bits, so the level carries no glitch
    assign irq = |(irq_status_r & irq_enable_r);
    assign write_busy = array_busy;
endmodule : eew_ctrl
`default_nettype wire

// ---- hdl/eew_pkg.sv ----
// Constants shared by the data EEPROM write control block
package eew_pkg;
    // Register offsets on the byte-wide register port
    localparam logic [7:0] OFS_BYTE_BUFFER = 8'h08;
    localparam logic [7:0] OFS_LOCATION_SELECT = 8'h09;
    localparam logic [7:0] OFS_CONTROL_STATUS = 8'h88;
    localparam logic [7:0] OFS_UNLOCK_PORT = 8'h89;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h8c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h8d;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h8e;

    // Control/status field positions
    localparam int BIT_READ_STROBE = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_WRITE_ENABLE = 2;
    localparam int BIT_WRITE_ERROR = 3;
    localparam int BIT_WRITE_COMPLETE = 4;

    // Interrupt status field positions
    localparam int IRQ_COMPLETE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_MISMATCH = 2;
    localparam int IRQ_WIDTH = 3;

    // Unlock keys
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;

    // Reset values and erased byte value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [IRQ_WIDTH-1:0] RST_IRQ = 3'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Array geometry
    localparam int ARRAY_DEPTH = 64;
    localparam int ARRAY_ADDR_W = 6;

    // Self-timed write duration
    localparam int CLK_PERIOD_NS = 25;
    localparam int WRITE_TIME_NS = 4000000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : eew_pkg

// ---- hdl/eew_unlock.sv ----
// Unlock sequence detector for the byte write start
`timescale 1ns/100ps
`default_nettype none
module eew_unlock
    import eew_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port writes
    input wire logic unlock_wr,
    input wire logic other_wr,
    input wire logic [7:0] wdata,
    // Status
    output logic armed
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRST = 3'b010,
        ST_ARMED = 3'b100
    } eew_unlock_state_t;

    eew_unlock_state_t state_r;
    eew_unlock_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (unlock_wr && wdata == UNLOCK_KEY_FIRST) begin // R02
                    state_nxt = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (unlock_wr && wdata == UNLOCK_KEY_SECOND) begin // R02
                    state_nxt = ST_ARMED;
                end else if (unlock_wr || other_wr) begin
                    state_nxt = ST_IDLE; // R18
                end
            end
            ST_ARMED: begin
                // Arming lasts for one further write only, used or not
                if (unlock_wr || other_wr) begin
                    state_nxt = ST_IDLE; // R18
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign armed = (state_r == ST_ARMED);
endmodule : eew_unlock
`default_nettype wire

// ---- testbench/eew_ctrl_checker.sv ----
// Port-level assertions for the EEPROM write control block
`timescale 1ns/100ps
`default_nettype none
module eew_ctrl_checker
    import eew_pkg::*;
#(
    parameter int WRITE_CYCLE_COUNT = WRITE_CYCLES
)
(
    // Clock and resets
    input wire logic clock,
    input wire logic reset,
    input wire logic warm_reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Interrupt and status
    input wire logic irq,
    input wire logic write_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [31:0] busy_cnt_r;
    wire key1 = reg_wr && reg_addr == OFS_UNLOCK_PORT && reg_wdata == UNLOCK_KEY_FIRST;
    wire key2 = reg_wr && reg_addr == OFS_UNLOCK_PORT && reg_wdata == UNLOCK_KEY_SECOND;
    wire go = reg_wr && reg_addr == OFS_CONTROL_STATUS && reg_wdata[BIT_WRITE_START];
    wire en_wr = reg_wr && reg_addr == OFS_IRQ_ENABLE;
    wire clr_wr = reg_wr && reg_addr == OFS_IRQ_CLEAR;
    wire rd_go = reg_wr && reg_addr == OFS_CONTROL_STATUS && reg_wdata[BIT_READ_STROBE];
    // Port-level model of the key sequence and of the enable bit
    logic [1:0] keys_r;
    logic en_r;
    wire go_ok = go && !warm_reset && keys_r == 2'h2 && en_r;

    // Cycles spent in the current timed write
    always_ff @(posedge clock) begin
        if (reset || !write_busy) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            keys_r <= 2'h0;
        end else if (key1 && keys_r == 2'h0) begin
            keys_r <= 2'h1;
        end else if (key2 && keys_r == 2'h1) begin
            keys_r <= 2'h2;
        end else if (reg_wr) begin
            keys_r <= 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || warm_reset) begin
            en_r <= 1'b0;
        end else if (reg_wr && reg_addr == OFS_CONTROL_STATUS) begin
            en_r <= reg_wdata[BIT_WRITE_ENABLE];
        end
    end

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_rd_wo;
        $past(reg_rd) && $past(reg_addr) == OFS_UNLOCK_PORT |-> reg_rdata == 8'h00;
    endproperty
    sequence s_armed_go;
        go_ok && !write_busy;
    endsequence
    sequence s_busy_next;
        ##1 write_busy;
    endsequence
    property p_start;
        $rose(write_busy) |-> $past(go_ok);
    endproperty
    property p_begin;
        s_armed_go |-> s_busy_next;
    endproperty
    property p_busy_len;
        $fell(write_busy) && !$past(warm_reset) && !$past(reset)
            |-> busy_cnt_r == WRITE_CYCLE_COUNT;
    endproperty
    property p_busy_hold;
        write_busy && !warm_reset && busy_cnt_r < WRITE_CYCLE_COUNT - 1 |=> write_busy;
    endproperty
    property p_irq_rise;
        $rose(irq) |-> $fell(write_busy) || $past(en_wr) || $past(rd_go, 2);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(clr_wr) || $past(en_wr);
    endproperty
    property p_abort;
        warm_reset |=> !write_busy;
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
    a_rd_wo: assert property (p_rd_wo) else $error("unlock port read not zero");
    a_start: assert property (p_start) else $error("write began without keys");
    a_begin: assert property (p_begin) else $error("unlocked start ignored");
    a_busy_len: assert property (p_busy_len) else $error("write length wrong");
    a_busy_hold: assert property (p_busy_hold) else $error("write cut short");
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell by itself");
    a_abort: assert property (p_abort) else $error("write kept after warm reset");
endmodule : eew_ctrl_checker

bind eew_ctrl eew_ctrl_checker #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) i_eew_ctrl_checker (
    .clock(clock), .reset(reset), .warm_reset(warm_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .write_busy(write_busy)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the EEPROM write control block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import eew_pkg::*;
;
    // Short write time keeps the run brief
    localparam int N = 20;
    localparam logic [7:0] CTL = OFS_CONTROL_STATUS;
    localparam logic [7:0] UNL = OFS_UNLOCK_PORT;
    localparam logic [7:0] BUF = OFS_BYTE_BUFFER;
    localparam logic [7:0] LOC = OFS_LOCATION_SELECT;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic warm_reset = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic write_busy;
    int n_fail = 0;
    int n_tests = 0;
    int busy_n = 0;

    always #12.5 clock = ~clock;
    always @(negedge clock) if (write_busy === 1'b1) busy_n++;

    eew_ctrl #(.WRITE_CYCLE_COUNT(N)) i_eew_ctrl (
        .clock(clock), .reset(reset), .warm_reset(warm_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .write_busy(write_busy)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd

    task automatic flags(input logic b, input logic i);
        @(negedge clock);
        check("busy", {7'h0, write_busy}, {7'h0, b});
        check("irq", {7'h0, irq}, {7'h0, i});
    endtask : flags

    task automatic start_write(input logic [7:0] loc, input logic [7:0] dat);
        busy_n = 0;
        wr(LOC, loc);
        wr(BUF, dat);
        wr(CTL, 8'h04);
        wr(UNL, UNLOCK_KEY_FIRST);
        wr(UNL, UNLOCK_KEY_SECOND);
        wr(CTL, 8'h06);
    endtask : start_write

    // Bounded so a stuck write ends in a mismatch, not a hang
    task automatic wait_done;
        @(negedge clock);
        for (int k = 0; k < 200 && write_busy === 1'b1; k++) @(negedge clock);
        check("busy cycles", busy_n[7:0], 8'(N));
    endtask : wait_done

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        rd(CTL, 8'h00);
        rd(BUF, RST_BYTE);
        rd(OFS_IRQ_STATUS, 8'h00);
        wr(UNL, UNLOCK_KEY_FIRST);
        rd(UNL, 8'h00);
        rd(OFS_IRQ_CLEAR, 8'h00);
        rd(8'h40, 8'h00);
        $display("test reset values done");
        // Enable and start in one write must not start
        // Any other write drops the half sequence left above
        wr(LOC, 8'h00);
        wr(UNL, UNLOCK_KEY_FIRST);
        wr(UNL, UNLOCK_KEY_SECOND);
        wr(CTL, 8'h06);
        flags(1'b0, 1'b0);
        rd(CTL, 8'h04);
        for (int k = 0; k < 2; k++) begin
            wr(UNL, k ? 8'h56 : UNLOCK_KEY_FIRST);
            if (k == 0) wr(BUF, 8'h11);
            wr(UNL, UNLOCK_KEY_SECOND);
            wr(CTL, 8'h06);
            flags(1'b0, 1'b0);
        end
        $display("test refused starts done");
        start_write(8'h3f, 8'ha5);
        flags(1'b1, 1'b0);
        wait_done();
        rd(CTL, 8'h14);
        flags(1'b0, 1'b0);
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_IRQ_ENABLE, 8'h01);
        rd(OFS_IRQ_ENABLE, 8'h01);
        flags(1'b0, 1'b1);
        repeat (5) @(posedge clock);
        rd(CTL, 8'h14);
        wr(CTL, 8'h04);
        rd(CTL, 8'h04);
        wr(OFS_IRQ_CLEAR, 8'h01);
        flags(1'b0, 1'b0);
        wr(BUF, 8'h00);
        wr(CTL, 8'h05);
        rd(CTL, 8'h04);
        rd(BUF, 8'ha5);
        $display("test full write done");
        start_write(8'h00, 8'h5a);
        wr(CTL, 8'h00);
        wait_done();
        rd(CTL, 8'h10);
        flags(1'b0, 1'b1);
        wr(OFS_IRQ_CLEAR, 8'h01);
        wr(BUF, 8'h00);
        wr(CTL, 8'h01);
        rd(BUF, 8'h5a);
        $display("test enable cleared mid write done");
        wr(CTL, 8'h00);
        start_write(8'h21, 8'h3c);
        repeat (3) @(posedge clock);
        warm_reset <= 1'b1;
        @(posedge clock);
        warm_reset <= 1'b0;
        flags(1'b0, 1'b0);
        rd(CTL, 8'h08);
        rd(BUF, 8'h3c);
        rd(LOC, 8'h21);
        rd(OFS_IRQ_STATUS, 8'h02);
        wr(CTL, 8'h01);
        rd(BUF, ERASED_BYTE);
        $display("test warm reset abort done");
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd(CTL, 8'h00);
        $display("test second reset done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
